// [core/csfr_bank.sv]
// core special register bank with the port registers for pins 0 to 14
//
// What this block does
// - stack pointer: byte, reset 07, pre-increment on push
// - sixteen-bit instruction counter, clears, advances on fetch
// - bank select bits choose register bank base
// - parity flag keeps accumulator parity even
// - carry bit7, aux carry bit6, user flag bit5
// - two pointers from separately writable low/high bytes
// - four port registers control pins 0-14
// - direction upper nibble, level lower nibble
// - direction one drives output, zero input
// - level one drives high, zero low
// - port reads return actual pin state
// - pins stay inputs until output gate set
// - reset values: ports ff, others listed
// - baud source register keeps only bit 7
// - multiply helper holds second operand/result
// - unimplemented reads return 00, writes ignored
// - pointer select bit 0 picks active pointer
// - addresses ending 0 or 8 bit addressable
`timescale 1ns/100ps
`include "csfr_defs.svh"

module csfr_bank #(
    parameter int NPINS = `CSFR_NPINS
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    // direct-address register port from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_bit_op,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    output logic [7:0] sfr_rdata,
    output logic sfr_rvalid,
    // core events
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic code_fetch,
    input wire logic flag_wr,
    input wire logic carry_in,
    input wire logic aux_carry_in,
    input wire logic signed_wrap_in,
    input wire logic mul_div_wr,
    input wire logic [7:0] mul_div_result,
    // output gate from configuration space
    input wire logic pin_output_gate,
    // pins, output enable low while driving
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe_n,
    // views used by the core datapath
    output logic [15:0] instruction_counter,
    output logic [7:0] stack_pointer,
    output logic [4:0] bank_base,
    output logic [15:0] active_data_pointer,
    output logic [7:0] mul_operand
);

    // the pin map below is laid out for fifteen pins only
    if (NPINS != `CSFR_NPINS) begin : g_npins_check
        $error("csfr_bank serves exactly fifteen pins");
    end

    csfr_pkg::csfr_state_type s_reg;
    csfr_pkg::csfr_state_type s_next;

    // bit addressable when address ends in 0 or 8
    function automatic logic csfr_bit_addressable(input logic [7:0] a);
        return (a[2:0] & `CSFR_BITADDR_MASK) == `CSFR_BITADDR_LOW;
    endfunction

    // merge a byte write or a single-bit write into an old value
    function automatic logic [7:0] csfr_merge(input logic [7:0] old, input logic [7:0] a);
        logic [7:0] v;
        v = sfr_wdata;
        if (sfr_bit_op) begin
            v = old;
            if (csfr_bit_addressable(a)) begin
                v[sfr_bit_sel] = sfr_bit_val;
            end
        end
        return v;
    endfunction

    // even parity over the accumulator
    function automatic logic csfr_parity(input logic [7:0] v);
        return ^v;
    endfunction

    // pin level read as seen on the pad; 15 pins laid into 4 bytes
    function automatic logic [7:0] csfr_port_read(input logic [7:0] latch, input int idx);
        logic [7:0] v;
        v = latch;
        case (idx)
            0: v[3:0] = pin_in[3:0];
            1: v[3:0] = pin_in[7:4];
            2: v[3:0] = pin_in[11:8];
            default: v[3:0] = pin_in[14:11];
        endcase
        return v;
    endfunction

    // next state
    always_comb begin
        logic wr;
        logic [7:0] sp_step;
        logic [14:0] dir;
        logic [14:0] lvl;
        logic [7:0] baud_v;
        baud_v = 8'h00;
        wr = 1'b0;
        sp_step = 8'h00;
        dir = 15'h0000;
        lvl = 15'h0000;
        s_next = s_reg;
        wr = sfr_wr;
        s_next.rvalid = 1'b0;

        // register writes; unmapped addresses fall through untouched
        if (wr) begin
            case (sfr_addr)
                `CSFR_ADDR_PORT0: s_next.port0 = csfr_merge(s_reg.port0, sfr_addr);
                `CSFR_ADDR_PORT1: s_next.port1 = csfr_merge(s_reg.port1, sfr_addr);
                `CSFR_ADDR_PORT2: s_next.port2 = csfr_merge(s_reg.port2, sfr_addr);
                `CSFR_ADDR_PORT3: s_next.port3 = csfr_merge(s_reg.port3, sfr_addr);
                `CSFR_ADDR_SP: s_next.sp = csfr_merge(s_reg.sp, sfr_addr);
                `CSFR_ADDR_DP0L: s_next.dp0l = csfr_merge(s_reg.dp0l, sfr_addr);
                `CSFR_ADDR_DP0H: s_next.dp0h = csfr_merge(s_reg.dp0h, sfr_addr);
                `CSFR_ADDR_DP1L: s_next.dp1l = csfr_merge(s_reg.dp1l, sfr_addr);
                `CSFR_ADDR_DP1H: s_next.dp1h = csfr_merge(s_reg.dp1h, sfr_addr);
                `CSFR_ADDR_SPEED: s_next.speed = csfr_merge(s_reg.speed, sfr_addr);
                `CSFR_ADDR_TCTL: s_next.tctl = csfr_merge(s_reg.tctl, sfr_addr);
                `CSFR_ADDR_TMODE: s_next.tmode = csfr_merge(s_reg.tmode, sfr_addr);
                `CSFR_ADDR_T0L: s_next.t0l = csfr_merge(s_reg.t0l, sfr_addr);
                `CSFR_ADDR_T1L: s_next.t1l = csfr_merge(s_reg.t1l, sfr_addr);
                `CSFR_ADDR_T0H: s_next.t0h = csfr_merge(s_reg.t0h, sfr_addr);
                `CSFR_ADDR_T1H: s_next.t1h = csfr_merge(s_reg.t1h, sfr_addr);
                `CSFR_ADDR_STRETCH: s_next.stretch = csfr_merge(s_reg.stretch, sfr_addr);
                `CSFR_ADDR_PSEL: s_next.psel = csfr_merge(s_reg.psel, sfr_addr);
                `CSFR_ADDR_S0CTL: s_next.s0ctl = csfr_merge(s_reg.s0ctl, sfr_addr);
                `CSFR_ADDR_SERIAL0_BUFFER: s_next.serial0_buffer = csfr_merge(s_reg.serial0_buffer, sfr_addr);
                `CSFR_ADDR_IRQ_ENABLE_TWO: s_next.irq_enable_two = csfr_merge(s_reg.irq_enable_two, sfr_addr);
                `CSFR_ADDR_S1CTL: s_next.s1ctl = csfr_merge(s_reg.s1ctl, sfr_addr);
                `CSFR_ADDR_SERIAL1_BUFFER: s_next.serial1_buffer = csfr_merge(s_reg.serial1_buffer, sfr_addr);
                `CSFR_ADDR_S1RLL: s_next.s1rll = csfr_merge(s_reg.s1rll, sfr_addr);
                `CSFR_ADDR_IRQ_ENABLE_ZERO: s_next.irq_enable_zero = csfr_merge(s_reg.irq_enable_zero, sfr_addr);
                `CSFR_ADDR_IPRI0: s_next.ipri0 = csfr_merge(s_reg.ipri0, sfr_addr);
                `CSFR_ADDR_S0RLL: s_next.s0rll = csfr_merge(s_reg.s0rll, sfr_addr);
                `CSFR_ADDR_IRQ_ENABLE_ONE: s_next.irq_enable_one = csfr_merge(s_reg.irq_enable_one, sfr_addr);
                `CSFR_ADDR_IPRI1: s_next.ipri1 = csfr_merge(s_reg.ipri1, sfr_addr);
                `CSFR_ADDR_S0RLH: s_next.s0rlh = csfr_merge(s_reg.s0rlh, sfr_addr);
                `CSFR_ADDR_S1RLH: s_next.s1rlh = csfr_merge(s_reg.s1rlh, sfr_addr);
                `CSFR_ADDR_PAGE: s_next.page = csfr_merge(s_reg.page, sfr_addr);
                `CSFR_ADDR_IRQC: s_next.irqc = csfr_merge(s_reg.irqc, sfr_addr);
                `CSFR_ADDR_XPOL: s_next.xpol = csfr_merge(s_reg.xpol, sfr_addr);
                `CSFR_ADDR_PSW: s_next.program_status_word = csfr_merge(s_reg.program_status_word, sfr_addr);
                `CSFR_ADDR_BAUD: begin
                    // only the top bit is stored; the rest of the byte is dropped
                    baud_v = csfr_merge({s_reg.baud_sel, 7'h00}, sfr_addr);
                    s_next.baud_sel = baud_v[`CSFR_BAUD_BIT];
                end
                `CSFR_ADDR_ACC: s_next.acc = csfr_merge(s_reg.acc, sfr_addr);
                `CSFR_ADDR_MULH: s_next.mulh = csfr_merge(s_reg.mulh, sfr_addr);
                default: s_next.rvalid = 1'b0;
            endcase
        end

        // flags from the core datapath override a software write the same cycle
        if (flag_wr) begin
            s_next.program_status_word[`CSFR_PSW_CY] = carry_in;
            s_next.program_status_word[`CSFR_PSW_AC] = aux_carry_in;
            s_next.program_status_word[`CSFR_PSW_OV] = signed_wrap_in;
        end
        // multiply/divide second result lands in the helper byte
        if (mul_div_wr) begin
            s_next.mulh = mul_div_result;
        end
        // parity is recomputed every cycle from the accumulator that will be held
        s_next.program_status_word[`CSFR_PSW_P] = csfr_parity(s_next.acc);

        // stack: increment before push, decrement after pop
        sp_step = `CSFR_STEP_ONE;
        if (stack_push) begin
            s_next.sp = s_next.sp + sp_step;
        end else if (stack_pop) begin
            s_next.sp = s_next.sp - sp_step;
        end

        // instruction counter advances on every code-space fetch
        if (code_fetch) begin
            s_next.pc = s_reg.pc + `CSFR_PC_STEP;
        end

        // register bank base address = bank number times eight
        s_next.bank_base = {s_next.program_status_word[`CSFR_PSW_RS1:`CSFR_PSW_RS0], 3'h0};

        // active pointer; both stay intact when switching
        if (s_next.psel[`CSFR_PSEL_BIT]) begin
            s_next.active_dp = {s_next.dp1h, s_next.dp1l};
        end else begin
            s_next.active_dp = {s_next.dp0h, s_next.dp0l};
        end

        // pin map: upper nibble direction, lower nibble level; port 3 bits 6:4 and 3:1 serve pins 12-14
        dir = {s_next.port3[6:4], s_next.port2[7:4], s_next.port1[7:4], s_next.port0[7:4]};
        lvl = {s_next.port3[3:1], s_next.port2[3:0], s_next.port1[3:0], s_next.port0[3:0]};
        s_next.pin_out = lvl;
        // gate low holds every pin as input so reset never glitches the pads
        s_next.pin_oe_n = ~(dir & {NPINS{pin_output_gate}});

        // reads: registered answer one cycle after the strobe
        if (sfr_rd) begin
            s_next.rvalid = 1'b1;
            case (sfr_addr)
                `CSFR_ADDR_PORT0: s_next.rdata = csfr_port_read(s_reg.port0, 0);
                `CSFR_ADDR_PORT1: s_next.rdata = csfr_port_read(s_reg.port1, 1);
                `CSFR_ADDR_PORT2: s_next.rdata = csfr_port_read(s_reg.port2, 2);
                `CSFR_ADDR_PORT3: s_next.rdata = csfr_port_read(s_reg.port3, 3);
                `CSFR_ADDR_SP: s_next.rdata = s_reg.sp;
                `CSFR_ADDR_DP0L: s_next.rdata = s_reg.dp0l;
                `CSFR_ADDR_DP0H: s_next.rdata = s_reg.dp0h;
                `CSFR_ADDR_DP1L: s_next.rdata = s_reg.dp1l;
                `CSFR_ADDR_DP1H: s_next.rdata = s_reg.dp1h;
                `CSFR_ADDR_SPEED: s_next.rdata = s_reg.speed;
                `CSFR_ADDR_TCTL: s_next.rdata = s_reg.tctl;
                `CSFR_ADDR_TMODE: s_next.rdata = s_reg.tmode;
                `CSFR_ADDR_T0L: s_next.rdata = s_reg.t0l;
                `CSFR_ADDR_T1L: s_next.rdata = s_reg.t1l;
                `CSFR_ADDR_T0H: s_next.rdata = s_reg.t0h;
                `CSFR_ADDR_T1H: s_next.rdata = s_reg.t1h;
                `CSFR_ADDR_STRETCH: s_next.rdata = s_reg.stretch;
                `CSFR_ADDR_PSEL: s_next.rdata = s_reg.psel;
                `CSFR_ADDR_S0CTL: s_next.rdata = s_reg.s0ctl;
                `CSFR_ADDR_SERIAL0_BUFFER: s_next.rdata = s_reg.serial0_buffer;
                `CSFR_ADDR_IRQ_ENABLE_TWO: s_next.rdata = s_reg.irq_enable_two;
                `CSFR_ADDR_S1CTL: s_next.rdata = s_reg.s1ctl;
                `CSFR_ADDR_SERIAL1_BUFFER: s_next.rdata = s_reg.serial1_buffer;
                `CSFR_ADDR_S1RLL: s_next.rdata = s_reg.s1rll;
                `CSFR_ADDR_IRQ_ENABLE_ZERO: s_next.rdata = s_reg.irq_enable_zero;
                `CSFR_ADDR_IPRI0: s_next.rdata = s_reg.ipri0;
                `CSFR_ADDR_S0RLL: s_next.rdata = s_reg.s0rll;
                `CSFR_ADDR_IRQ_ENABLE_ONE: s_next.rdata = s_reg.irq_enable_one;
                `CSFR_ADDR_IPRI1: s_next.rdata = s_reg.ipri1;
                `CSFR_ADDR_S0RLH: s_next.rdata = s_reg.s0rlh;
                `CSFR_ADDR_S1RLH: s_next.rdata = s_reg.s1rlh;
                `CSFR_ADDR_PAGE: s_next.rdata = s_reg.page;
                `CSFR_ADDR_IRQC: s_next.rdata = s_reg.irqc;
                `CSFR_ADDR_XPOL: s_next.rdata = s_reg.xpol;
                `CSFR_ADDR_PSW: s_next.rdata = s_reg.program_status_word;
                `CSFR_ADDR_BAUD: s_next.rdata = {s_reg.baud_sel, 7'h00};
                `CSFR_ADDR_ACC: s_next.rdata = s_reg.acc;
                `CSFR_ADDR_MULH: s_next.rdata = s_reg.mulh;
                default: s_next.rdata = `CSFR_UNDEF_READ;
            endcase
        end
    end

    // state register; reset loads the listed values
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.port0 <= `CSFR_RST_PORT;
            s_reg.port1 <= `CSFR_RST_PORT;
            s_reg.port2 <= `CSFR_RST_PORT;
            s_reg.port3 <= `CSFR_RST_PORT;
            s_reg.sp <= `CSFR_RST_SP;
            s_reg.stretch <= `CSFR_RST_STRETCH;
            s_reg.s0rll <= `CSFR_RST_S0RLL;
            s_reg.s0rlh <= `CSFR_RST_RLH;
            s_reg.s1rlh <= `CSFR_RST_RLH;
            s_reg.pc <= `CSFR_RST_PC;
            s_reg.pin_oe_n <= '1;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state flops
    assign sfr_rdata = s_reg.rdata;
    assign sfr_rvalid = s_reg.rvalid;
    assign pin_out = s_reg.pin_out;
    assign pin_oe_n = s_reg.pin_oe_n;
    assign instruction_counter = s_reg.pc;
    assign stack_pointer = s_reg.sp;
    assign bank_base = s_reg.bank_base;
    assign active_data_pointer = s_reg.active_dp;
    assign mul_operand = s_reg.mulh;

endmodule // csfr_bank

// [core/csfr_defs.svh]
// constants for the core special register bank: addresses, reset values, fields
`ifndef CSFR_DEFS_SVH
`define CSFR_DEFS_SVH

`define CSFR_ADDR_PORT0 8'h80
`define CSFR_ADDR_SP 8'h81
`define CSFR_ADDR_DP0L 8'h82
`define CSFR_ADDR_DP0H 8'h83
`define CSFR_ADDR_DP1L 8'h84
`define CSFR_ADDR_DP1H 8'h85
`define CSFR_ADDR_SPEED 8'h87
`define CSFR_ADDR_TCTL 8'h88
`define CSFR_ADDR_TMODE 8'h89
`define CSFR_ADDR_T0L 8'h8a
`define CSFR_ADDR_T1L 8'h8b
`define CSFR_ADDR_T0H 8'h8c
`define CSFR_ADDR_T1H 8'h8d
`define CSFR_ADDR_STRETCH 8'h8e
`define CSFR_ADDR_PORT1 8'h90
`define CSFR_ADDR_PSEL 8'h92
`define CSFR_ADDR_S0CTL 8'h98
`define CSFR_ADDR_SERIAL0_BUFFER 8'h99
`define CSFR_ADDR_IRQ_ENABLE_TWO 8'h9a
`define CSFR_ADDR_S1CTL 8'h9b
`define CSFR_ADDR_SERIAL1_BUFFER 8'h9c
`define CSFR_ADDR_S1RLL 8'h9d
`define CSFR_ADDR_PORT2 8'ha0
`define CSFR_ADDR_IRQ_ENABLE_ZERO 8'ha8
`define CSFR_ADDR_IPRI0 8'ha9
`define CSFR_ADDR_S0RLL 8'haa
`define CSFR_ADDR_PORT3 8'hb0
`define CSFR_ADDR_IRQ_ENABLE_ONE 8'hb8
`define CSFR_ADDR_IPRI1 8'hb9
`define CSFR_ADDR_S0RLH 8'hba
`define CSFR_ADDR_S1RLH 8'hbb
`define CSFR_ADDR_PAGE 8'hbf
`define CSFR_ADDR_IRQC 8'hc0
`define CSFR_ADDR_XPOL 8'hc8
`define CSFR_ADDR_PSW 8'hd0
`define CSFR_ADDR_BAUD 8'hd8
`define CSFR_ADDR_ACC 8'he0
`define CSFR_ADDR_MULH 8'hf0

`define CSFR_RST_ZERO 8'h00
`define CSFR_RST_PORT 8'hff
`define CSFR_RST_SP 8'h07
`define CSFR_RST_STRETCH 8'h01
`define CSFR_RST_S0RLL 8'hd9
`define CSFR_RST_RLH 8'h03
`define CSFR_RST_PC 16'h0000
`define CSFR_UNDEF_READ 8'h00

// status word fields, other bit positions, steps and sizes
`define CSFR_PSW_CY 7
`define CSFR_PSW_AC 6
`define CSFR_PSW_F0 5
`define CSFR_PSW_RS1 4
`define CSFR_PSW_RS0 3
`define CSFR_PSW_OV 2
`define CSFR_PSW_P 0
`define CSFR_BAUD_BIT 7
`define CSFR_PSEL_BIT 0
`define CSFR_BANK_SHIFT 3
`define CSFR_STEP_ONE 8'h01
`define CSFR_PC_STEP 16'h0001
`define CSFR_BITADDR_MASK 3'h7
`define CSFR_BITADDR_LOW 3'h0
`define CSFR_NPINS 15

`endif

// [core/csfr_pkg.sv]
// types for the core special register bank
package csfr_pkg;
    typedef struct packed {
        logic [7:0] port0;
        logic [7:0] port1;
        logic [7:0] port2;
        logic [7:0] port3;
        logic [7:0] sp;
        logic [7:0] dp0l;
        logic [7:0] dp0h;
        logic [7:0] dp1l;
        logic [7:0] dp1h;
        logic [7:0] speed;
        logic [7:0] tctl;
        logic [7:0] tmode;
        logic [7:0] t0l;
        logic [7:0] t1l;
        logic [7:0] t0h;
        logic [7:0] t1h;
        logic [7:0] stretch;
        logic [7:0] psel;
        logic [7:0] s0ctl;
        logic [7:0] serial0_buffer;
        logic [7:0] irq_enable_two;
        logic [7:0] s1ctl;
        logic [7:0] serial1_buffer;
        logic [7:0] s1rll;
        logic [7:0] irq_enable_zero;
        logic [7:0] ipri0;
        logic [7:0] s0rll;
        logic [7:0] irq_enable_one;
        logic [7:0] ipri1;
        logic [7:0] s0rlh;
        logic [7:0] s1rlh;
        logic [7:0] page;
        logic [7:0] irqc;
        logic [7:0] xpol;
        logic [7:0] program_status_word;
        logic baud_sel;
        logic [7:0] acc;
        logic [7:0] mulh;
        logic [15:0] pc;
        logic [7:0] rdata;
        logic rvalid;
        logic [14:0] pin_out;
        logic [14:0] pin_oe_n;
        logic [4:0] bank_base;
        logic [15:0] active_dp;
    } csfr_state_type;
endpackage

// [verification/csfr_bank_chk.sv]
// assertion checker for the core special register bank
`timescale 1ns/100ps
module csfr_bank_chk #(
    parameter int NPINS = 15
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_bit_op,
    input wire logic sfr_rvalid,
    // core events
    input wire logic stack_push,
    input wire logic code_fetch,
    input wire logic flag_wr,
    input wire logic mul_div_wr,
    input wire logic [7:0] mul_div_result,
    // pins and views
    input wire logic pin_output_gate,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe_n,
    input wire logic [15:0] instruction_counter,
    input wire logic [7:0] stack_pointer,
    input wire logic [4:0] bank_base,
    input wire logic [7:0] mul_operand
);
    default clocking chk_cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // whole-byte write taken on this edge; bit ops follow their own path
    logic wr_byte;
    assign wr_byte = sfr_wr && clk_en && !sfr_bit_op;

    // every check ties a registered output to the request one edge earlier
    a_read_answer: assert property (sfr_rd && clk_en |=> sfr_rvalid)
        else $error("read not answered one cycle later");
    a_pc_advance: assert property (code_fetch && clk_en |=> instruction_counter ==
        $past(instruction_counter) + 16'h0001) else $error("counter did not advance by one");
    a_sp_push: assert property (stack_push && clk_en && !(sfr_wr && sfr_addr == 8'h81)
        |=> stack_pointer == $past(stack_pointer) + 8'h01) else $error("push did not pre-increment");
    a_bank_select: assert property (wr_byte && !flag_wr && sfr_addr == 8'hd0
        |=> bank_base == {$past(sfr_wdata[4:3]), 3'h0}) else $error("bank base wrong");
    a_gate_blocks: assert property (!pin_output_gate && clk_en |=> pin_oe_n == '1)
        else $error("pin driven while output gate is low");
    a_port0_dir: assert property (wr_byte && pin_output_gate && sfr_addr == 8'h80
        |=> pin_oe_n[3:0] == ~$past(sfr_wdata[7:4])) else $error("port 0 direction wrong");
    a_port0_level: assert property (wr_byte && pin_output_gate && sfr_addr == 8'h80
        |=> ((pin_out[3:0] ^ $past(sfr_wdata[3:0])) & $past(sfr_wdata[7:4])) == 4'h0)
        else $error("port 0 drive level wrong");
    a_mul_load: assert property (mul_div_wr && clk_en |=> mul_operand == $past(mul_div_result))
        else $error("multiply helper not loaded");
    a_freeze_state: assert property (!clk_en |=> $stable(stack_pointer)
        && $stable(instruction_counter) && $stable(mul_operand)) else $error("state moved while frozen");
endmodule // csfr_bank_chk

bind csfr_bank csfr_bank_chk #(.NPINS(NPINS)) u_csfr_bank_chk (
    .clk_sys, .reset, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_bit_op,
    .sfr_rvalid, .stack_push, .code_fetch, .flag_wr, .mul_div_wr, .mul_div_result,
    .pin_output_gate, .pin_out, .pin_oe_n, .instruction_counter, .stack_pointer,
    .bank_base, .mul_operand
);

// [verification/csfr_bank_tb_top.sv]
// self-checking bench for the core special register bank
`timescale 1ns/100ps
module csfr_bank_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic pin_output_gate = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic sfr_bit_op = 1'b0;
    logic sfr_bit_val = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic [2:0] flg = 3'h5;
    logic [4:0] ev = 5'h00;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, stack_pointer, mul_operand;
    logic sfr_rvalid;
    logic [14:0] pin_in, pin_out, pin_oe_n;
    logic [14:0] pad_ext = 15'h2a5c;
    logic [15:0] instruction_counter, active_data_pointer;
    logic [4:0] bank_base;
    int n_fail = 0;
    int n_compared = 0;
    // address and value after reset; port rows carry the outside pad nibble
    localparam logic [15:0] RV [38] = '{16'h80fc, 16'h8107, 16'h8200, 16'h8300, 16'h8400,
        16'h8500, 16'h8700, 16'h8800, 16'h8900, 16'h8a00, 16'h8b00, 16'h8c00, 16'h8d00,
        16'h8e01, 16'h90f5, 16'h9200, 16'h9800, 16'h9900, 16'h9a00, 16'h9b00, 16'h9c00,
        16'h9d00, 16'ha0fa, 16'ha800, 16'ha900, 16'haad9, 16'hb0f5, 16'hb800, 16'hb900,
        16'hba03, 16'hbb03, 16'hbf00, 16'hc000, 16'hc800, 16'hd000, 16'hd800, 16'he000,
        16'hf000};
    localparam logic [7:0] RW [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8e, 8'h9d,
        8'haa, 8'hbb, 8'hf0};

    csfr_bank #(.NPINS(15)) u_csfr_bank (
        .clk_sys, .reset, .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_bit_op,
        .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .sfr_rvalid, .stack_push(ev[0]),
        .stack_pop(ev[1]), .code_fetch(ev[2]), .flag_wr(ev[3]), .mul_div_wr(ev[4]),
        .carry_in(flg[2]), .aux_carry_in(flg[1]), .signed_wrap_in(flg[0]),
        .mul_div_result(8'h96), .pin_output_gate, .pin_in, .pin_out, .pin_oe_n,
        .instruction_counter, .stack_pointer, .bank_base, .active_data_pointer, .mul_operand
    );

    // 125 MHz system clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // pads follow the device where it drives, else the outside level
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            pin_in[i] = (pin_oe_n[i] === 1'b0) ? pin_out[i] : pad_ext[i];
        end
    end

    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // byte write, or bit op with the bit number in d[3:1] and its value in d[0]
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bo = 1'b0);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_bit_sel <= d[3:1];
        sfr_bit_val <= d[0];
        sfr_bit_op <= bo;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        sfr_bit_op <= 1'b0;
        @(negedge clk_sys);
    endtask

    // read with a bounded wait for the valid pulse
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int i;
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        // the answer flop updates on this edge; look at it mid-cycle
        @(negedge clk_sys);
        for (i = 0; i < 4 && sfr_rvalid !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        if (sfr_rvalid !== 1'b1) begin
            n_fail++;
            end_of_test();
        end else begin
            check(sfr_rdata, e);
        end
    endtask

    // one-cycle event pulse on the core event inputs
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 5'h00;
        @(negedge clk_sys);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check(pin_oe_n, 15'h7fff);
        foreach (RV[i]) rd(RV[i][15:8], RV[i][7:0]);
        foreach (RW[i]) begin
            wr(RW[i], RW[i] ^ 8'h3c);
            rd(RW[i], RW[i] ^ 8'h3c);
        end
        wr(8'h86, 8'h55);
        rd(8'h86, 8'h00);
        wr(8'hd8, 8'hff);
        rd(8'hd8, 8'h80);
        for (int b = 0; b < 4; b++) begin
            wr(8'hd0, 8'(b << 3));
            check(bank_base, 16'(b * 8));
        end
        // bit ops land only where the address ends in 0 or 8
        wr(8'hd0, 8'h08, 1'b1);
        check(bank_base, 16'h0008);
        wr(8'h81, 8'h03, 1'b1);
        check(stack_pointer, 16'h00bd);
        wr(8'he0, 8'h07);
        rd(8'hd0, 8'h09);
        wr(8'hd0, 8'h20);
        rd(8'hd0, 8'h21);
        pulse(5'h08);
        rd(8'hd0, 8'ha5);
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        wr(8'h84, 8'h78);
        wr(8'h85, 8'h56);
        wr(8'h92, 8'h01);
        check(active_data_pointer, 16'h5678);
        wr(8'h92, 8'h00);
        check(active_data_pointer, 16'h1234);
        repeat (3) pulse(5'h04);
        check(instruction_counter, 16'h0003);
        pulse(5'h10);
        rd(8'hf0, 8'h96);
        check(mul_operand, 16'h0096);
        // pins stay quiet until the gate opens, then reads show the pads
        wr(8'h80, 8'h35);
        check(pin_oe_n, 15'h7fff);
        @(posedge clk_sys);
        pin_output_gate <= 1'b1;
        wr(8'h80, 8'h35);
        check(pin_oe_n, 15'h000c);
        check(pin_out & ~pin_oe_n, 15'h7ff1);
        rd(8'h80, 8'h3d);
        wr(8'hb0, 8'h70);
        rd(8'hb0, 8'h71);
        wr(8'h80, 8'h00, 1'b1);
        rd(8'h80, 8'h3c);
        // a frozen enable must drop both events and writes
        @(posedge clk_sys);
        clk_en <= 1'b0;
        pulse(5'h04);
        wr(8'h81, 8'h00);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        check(instruction_counter, 16'h0003);
        rd(8'h81, 8'hbd);
        // second reset in mid-run
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check(stack_pointer, 16'h0007);
        check(pin_oe_n, 15'h7fff);
        rd(8'h80, 8'hff);
        pulse(5'h01);
        check(stack_pointer, 16'h0008);
        pulse(5'h02);
        check(stack_pointer, 16'h0007);
        pulse(5'h03);
        check(stack_pointer, 16'h0008);
        end_of_test();
    end
endmodule // csfr_bank_tb_top
